// file: hw/wdt_defs.svh
// Purpose: Constants of the windowed watchdog timer
// Assumes: 250 MHz system clock, 32 kHz nominal oscillator
// Notes:   Definitions only
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ****************************************************************
// Clock figures
// ****************************************************************
`define WDT_CLK_HZ 250000000
`define WDT_OSC_HZ 32000
// Oscillator period in system clocks, rounded down
`define WDT_OSC_DIV (`WDT_CLK_HZ / `WDT_OSC_HZ)
`define WDT_OSC_CNT_W 13

// ****************************************************************
// Prescaler and postscaler
// ****************************************************************
`define WDT_PRE_DIV_SHORT 22'h000020
`define WDT_PRE_DIV_LONG 22'h000080
`define WDT_BASE_PERIOD_SHORT_MS 1
`define WDT_BASE_PERIOD_LONG_MS 4
`define WDT_POST_W 4
`define WDT_ELAPSED_W 22

`endif

// file: hw/wdt_pkg.sv
// Purpose: Types of the windowed watchdog timer
// Assumes: wdt_defs.svh gives the widths
// Notes:   State of each module is one packed struct
`include "wdt_defs.svh"

package wdt_pkg;

  // ****************************************************************
  // Power state of the core as seen by the watchdog
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_IDLE = 2'b10
  } pm_state_t;

  // ****************************************************************
  // Oscillator tick generator state
  // ****************************************************************
  typedef struct packed {
    logic [`WDT_OSC_CNT_W-1:0] cnt;
    logic tick;
  } osc_state_t;

  // ****************************************************************
  // Watchdog state
  // ****************************************************************
  typedef struct packed {
    pm_state_t pm;
    logic [`WDT_ELAPSED_W-1:0] elapsed;
    logic soft_enable;
    logic osc_enable;
    logic timeout_flag;
    logic sleep_flag;
    logic idle_flag;
    logic reset_req;
    logic wake_req;
  } wdt_state_t;

endpackage

// file: hw/osc_tick_gen.sv
// Purpose: One-cycle tick at the low-power oscillator rate
// Assumes: Oscillator modelled as a divider of the system clock
// Notes:   Restart zeroes the phase so a new count starts whole
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.svh"

module osc_tick_gen
  import wdt_pkg::*;
#(
  parameter int OSC_DIV = `WDT_OSC_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic restart,
  // Tick out
  output logic tick
);

  osc_state_t cur_reg;
  osc_state_t cur_next;

  // Phase counter, runs only while the oscillator is on
  always_comb begin
    cur_next = cur_reg;
    cur_next.tick = 1'b0;
    if (!enable || restart) begin
      cur_next.cnt = '0;
    end else if (cur_reg.cnt == `WDT_OSC_CNT_W'(OSC_DIV - 1)) begin
      cur_next.cnt = '0;
      cur_next.tick = 1'b1;
    end else begin
      cur_next.cnt = cur_reg.cnt + `WDT_OSC_CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign tick = cur_reg.tick;

endmodule // osc_tick_gen

`default_nettype wire

// file: hw/windowed_watchdog_timer.sv
// Purpose: Windowed watchdog timer with prescaler and postscaler
// Assumes: Single 250 MHz clock; oscillator modelled by a tick divider
// Notes:   Configuration and control bits are plain ports
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.svh"

module windowed_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int OSC_DIV = `WDT_OSC_DIV
) (
  // Clock and device reset
  input wire logic clk,
  input wire logic rst,
  // Configuration word fields
  input wire logic hard_enable_fuse,
  input wire logic window_disable,
  input wire logic prescale_select,
  input wire logic [`WDT_POST_W-1:0] postscale_select,
  // Soft enable write port
  input wire logic soft_enable_wr,
  input wire logic soft_enable_wdata,
  // Core events, one-cycle pulses
  input wire logic clear_watchdog_instr,
  input wire logic power_save_instr,
  input wire logic power_save_idle,
  input wire logic clock_switch_done,
  input wire logic wake_event,
  // Software clears of status flags
  input wire logic timeout_flag_clr,
  input wire logic sleep_flag_clr,
  input wire logic idle_flag_clr,
  // Status and requests
  output logic soft_enable,
  output logic osc_enable,
  output logic timeout_flag,
  output logic sleep_flag,
  output logic idle_flag,
  output logic in_sleep,
  output logic in_idle,
  output logic wdt_reset_req,
  output logic wake_req
);

  // ****************************************************************
  // Period decoding
  // ****************************************************************

  // Full period in oscillator ticks: prescale ratio shifted by code
  function automatic logic [`WDT_ELAPSED_W-1:0] period_of(
    input logic pre,
    input logic [`WDT_POST_W-1:0] post
  );
    logic [`WDT_ELAPSED_W-1:0] base;
    base = pre ? `WDT_PRE_DIV_LONG : `WDT_PRE_DIV_SHORT;
    return base << post;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wdt_state_t cur_reg;
  wdt_state_t cur_next;
  logic run;
  logic tick;
  logic in_run;
  logic [`WDT_ELAPSED_W-1:0] period;
  logic [`WDT_ELAPSED_W-1:0] last_count;
  logic [`WDT_ELAPSED_W-1:0] window_start;
  logic expire;
  logic win_open;
  logic good_clear;
  logic early_clear;
  logic enter_ps;
  logic leave_ps;
  logic restart;

  // ****************************************************************
  // Enable and oscillator tick
  // ****************************************************************

  // Fuse forces running, otherwise the soft bit decides
  assign run = hard_enable_fuse | cur_reg.soft_enable;

  // Oscillator divider, phase cleared on every restart
  osc_tick_gen #(
    .OSC_DIV(OSC_DIV)
  ) u_osc (
    .clk(clk),
    .rst(rst),
    .enable(run),
    .restart(restart),
    .tick(tick)
  );

  // ****************************************************************
  // Event decoding
  // ****************************************************************

  // Period, last count and start of the last quarter
  assign period = period_of(prescale_select, postscale_select);
  assign last_count = period - `WDT_ELAPSED_W'(1);
  // Taken from the last count: the top period wraps to zero in this width
  assign window_start = last_count - (last_count >> 2);

  // Counter reaches its last count on an oscillator tick
  assign in_run = (cur_reg.pm == ST_RUN);
  assign expire = run & tick & (cur_reg.elapsed == last_count);
  assign win_open = (cur_reg.elapsed >= window_start);

  // Clear allowed in run at any count in non-window mode, late only in window mode
  assign good_clear = in_run & clear_watchdog_instr & (window_disable | win_open);
  assign early_clear = run & in_run & clear_watchdog_instr & ~window_disable & ~win_open;

  // Power-save entry and exit
  assign enter_ps = in_run & power_save_instr;
  assign leave_ps = ~in_run & (expire | wake_event);

  // Any event that starts the count from zero
  assign restart = clock_switch_done
                 | good_clear
                 | enter_ps
                 | leave_ps
                 | expire
                 | ~run;

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Counter, power state, flags and one-cycle requests
  always_comb begin
    cur_next = cur_reg;
    cur_next.reset_req = 1'b0;
    cur_next.wake_req = 1'b0;
    cur_next.osc_enable = run;

    // Soft enable written by software
    if (soft_enable_wr) begin
      cur_next.soft_enable = soft_enable_wdata;
    end

    // Elapsed tick count, prescaler in the low bits
    if (restart) begin
      cur_next.elapsed = '0;
    end else if (tick) begin
      cur_next.elapsed = cur_reg.elapsed + `WDT_ELAPSED_W'(1);
    end

    // Software clears first so that a set in the same cycle wins
    if (timeout_flag_clr) begin
      cur_next.timeout_flag = 1'b0;
    end
    if (sleep_flag_clr) begin
      cur_next.sleep_flag = 1'b0;
    end
    if (idle_flag_clr) begin
      cur_next.idle_flag = 1'b0;
    end

    // Power state sequencing
    case (cur_reg.pm)
      ST_RUN: begin
        if (expire || early_clear) begin
          cur_next.reset_req = 1'b1;
          cur_next.timeout_flag = 1'b1;
        end else if (power_save_instr) begin
          if (power_save_idle) begin
            cur_next.pm = ST_IDLE;
            cur_next.idle_flag = 1'b1;
          end else begin
            cur_next.pm = ST_SLEEP;
            cur_next.sleep_flag = 1'b1;
          end
        end
      end
      ST_SLEEP, ST_IDLE: begin
        if (expire) begin
          cur_next.wake_req = 1'b1;
          cur_next.timeout_flag = 1'b1;
          cur_next.pm = ST_RUN;
        end else if (wake_event) begin
          cur_next.pm = ST_RUN;
        end
      end
      default: begin
        cur_next.pm = ST_RUN;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Device reset clears everything, soft enable included
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // All taken straight from the state register
  assign soft_enable = cur_reg.soft_enable;
  assign osc_enable = cur_reg.osc_enable;
  assign timeout_flag = cur_reg.timeout_flag;
  assign sleep_flag = cur_reg.sleep_flag;
  assign idle_flag = cur_reg.idle_flag;
  assign in_sleep = (cur_reg.pm == ST_SLEEP);
  assign in_idle = (cur_reg.pm == ST_IDLE);
  assign wdt_reset_req = cur_reg.reset_req;
  assign wake_req = cur_reg.wake_req;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Counter back at zero
  sequence s_restarted;
    cur_reg.elapsed == '0;
  endsequence

  // Count restarted and back in normal execution
  sequence s_resumed;
    s_restarted ##0 in_run;
  endsequence

  // Oscillator on one cycle after the watchdog runs
  a_osc_follows_run: assert property (run |=> osc_enable)
    else $error("oscillator off while watchdog runs");

  // Time-out lands on a whole number of prescaler periods
  a_pre_ratio: assert property (expire |-> (prescale_select ? cur_reg.elapsed[6:0] == 7'h7f
      : cur_reg.elapsed[4:0] == 5'h1f))
    else $error("time-out not on prescaler boundary");

  // Time-out only on the last count of the selected period
  a_post_ratio: assert property (expire |-> cur_reg.elapsed + `WDT_ELAPSED_W'(1)
      == ((prescale_select ? 22'h000080 : 22'h000020) << postscale_select))
    else $error("time-out not at postscaled period");

  // Counter and soft enable clear after reset
  a_reset_clears: assert property ($fell(rst) |-> s_restarted ##0 !soft_enable)
    else $error("state not cleared by reset");

  // Clock switch restarts the count
  a_switch_restart: assert property (run && clock_switch_done |=> s_restarted)
    else $error("clock switch did not restart count");

  // Power-save entry restarts the count and leaves run
  a_enter_ps: assert property (in_run && power_save_instr && !expire && !early_clear
      |=> s_restarted ##0 !in_run)
    else $error("power-save entry mishandled");

  // Time-out in power save wakes, restarts and resumes
  a_wake_timeout: assert property (!in_run && expire
      |=> s_resumed ##0 wake_req ##0 timeout_flag)
    else $error("time-out in power save did not wake");

  // Accepted clear restarts the count without a reset
  a_clear_restart: assert property (good_clear |=> s_restarted ##0 !wdt_reset_req)
    else $error("clear did not restart count");

  // Count advances on a tick while in power save
  a_count_in_save: assert property (!in_run && tick && !restart
      |=> cur_reg.elapsed == $past(cur_reg.elapsed) + `WDT_ELAPSED_W'(1))
    else $error("count stalled in power save");

  // Time-out flag stays set until cleared
  a_flag_sticky: assert property (timeout_flag && !timeout_flag_clr |=> timeout_flag)
    else $error("time-out flag dropped by itself");

  // Fuse keeps the watchdog running regardless of soft bit
  a_fuse_forces: assert property (hard_enable_fuse && soft_enable_wr && !soft_enable_wdata
      |=> osc_enable)
    else $error("fuse did not force watchdog on");

  // Without fuse or soft bit the watchdog stops
  a_soft_off: assert property (!hard_enable_fuse && !soft_enable
      |=> !osc_enable ##0 s_restarted)
    else $error("watchdog runs while disabled");

  // Early clear in window mode gives a reset the next cycle
  a_early_clear: assert property (early_clear |=> wdt_reset_req ##1 !wdt_reset_req)
    else $error("early clear did not reset");

  // Time-out in run requests a device reset
  a_run_timeout: assert property (in_run && expire |=> wdt_reset_req && timeout_flag)
    else $error("time-out in run gave no reset");

endmodule // windowed_watchdog_timer

`default_nettype wire

// file: tb/test_windowed_watchdog_timer.sv
// Purpose: Self-checking bench for the windowed watchdog timer
// Assumes: Oscillator divider shortened to 4 clocks per tick
// Notes:   Inputs change at the falling edge, outputs sampled there
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.svh"

module test_windowed_watchdog_timer;
  import wdt_pkg::*;

  // ****************************************************************
  // Signals and counters
  // ****************************************************************
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hard_enable_fuse = 1'b1;
  logic window_disable = 1'b1;
  logic prescale_select = 1'b0;
  logic [`WDT_POST_W-1:0] postscale_select = 4'h0;
  logic soft_enable_wr = 1'b0;
  logic soft_enable_wdata = 1'b0;
  logic clear_watchdog_instr = 1'b0;
  logic power_save_instr = 1'b0;
  logic power_save_idle = 1'b0;
  logic clock_switch_done = 1'b0;
  logic wake_event = 1'b0;
  logic timeout_flag_clr = 1'b0;
  logic sleep_flag_clr = 1'b0;
  logic idle_flag_clr = 1'b0;
  logic soft_enable, osc_enable, timeout_flag, sleep_flag, idle_flag;
  logic in_sleep, in_idle, wdt_reset_req, wake_req;
  int errors = 0;
  int checks_done = 0;

  // ****************************************************************
  // Design under test
  // ****************************************************************
  windowed_watchdog_timer #(.OSC_DIV(DIV)) DUT (
    .clk(clk), .rst(rst),
    .hard_enable_fuse(hard_enable_fuse), .window_disable(window_disable),
    .prescale_select(prescale_select), .postscale_select(postscale_select),
    .soft_enable_wr(soft_enable_wr), .soft_enable_wdata(soft_enable_wdata),
    .clear_watchdog_instr(clear_watchdog_instr), .power_save_instr(power_save_instr),
    .power_save_idle(power_save_idle), .clock_switch_done(clock_switch_done),
    .wake_event(wake_event), .timeout_flag_clr(timeout_flag_clr),
    .sleep_flag_clr(sleep_flag_clr), .idle_flag_clr(idle_flag_clr),
    .soft_enable(soft_enable), .osc_enable(osc_enable), .timeout_flag(timeout_flag),
    .sleep_flag(sleep_flag), .idle_flag(idle_flag), .in_sleep(in_sleep),
    .in_idle(in_idle), .wdt_reset_req(wdt_reset_req), .wake_req(wake_req)
  );

  // ****************************************************************
  // Clock and shared tasks
  // ****************************************************************
  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // Count a compare, report a mismatch
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Time-out count must sit near the expected clocks
  task automatic in_range(input string what, input int n, input int exp);
    check(what, 32'(n >= exp - DIV - 3 && n <= exp + 2 * DIV + 4), 32'h1);
  endtask

  // One-cycle pulse on a core event input
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  // Device reset held for six cycles
  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
  endtask

  // Cycles until reset request or wake request, bounded
  task automatic wait_for(input int lim, input bit wake, output int n);
    n = 0;
    while ((wake ? wake_req : wdt_reset_req) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Periods for each prescale and short postscale code
  task automatic t_period();
    int n;
    logic [31:0] full;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < (p ? 3 : 6); c++) begin
        prescale_select = p[0];
        postscale_select = c[3:0];
        do_reset();
        check("soft_enable", soft_enable, 32'h0);
        check("osc_enable", osc_enable, 32'h1);
        wait_for(20000, 1'b0, n);
        in_range("period", n, ((p ? 128 : 32) << c) * DIV);
        check("timeout_flag", timeout_flag, 32'h1);
        @(negedge clk);
        check("reset_req_width", wdt_reset_req, 32'h0);
      end
    end
    repeat (10) @(negedge clk);
    check("flag_sticky", timeout_flag, 32'h1);
    pulse(timeout_flag_clr);
    check("flag_cleared", timeout_flag, 32'h0);
    // Top codes too long to run out, so the decoded period is inspected
    for (int c = 14; c < 16; c++) begin
      prescale_select = c[0];
      postscale_select = c[3:0];
      @(negedge clk);
      full = (c[0] ? 32'd128 : 32'd32) << c;
      check("period_code", 32'(DUT.last_count) + 32'h1, full);
      check("window_code", 32'(DUT.window_start), full - (full >> 2));
    end
    prescale_select = 1'b0;
    postscale_select = 4'h0;
    $display("test period done");
  endtask

  // Soft enable decides when the fuse is clear
  task automatic t_soft();
    int n;
    hard_enable_fuse = 1'b0;
    do_reset();
    check("osc_off", osc_enable, 32'h0);
    wait_for(300, 1'b0, n);
    check("no_timeout", n, 32'd300);
    soft_enable_wdata = 1'b1;
    pulse(soft_enable_wr);
    check("soft_set", soft_enable, 32'h1);
    @(negedge clk);
    check("osc_on", osc_enable, 32'h1);
    wait_for(400, 1'b0, n);
    in_range("soft_period", n, 32 * DIV - 1);
    do_reset();
    check("soft_reset", soft_enable, 32'h0);
    hard_enable_fuse = 1'b1;
    soft_enable_wdata = 1'b0;
    pulse(soft_enable_wr);
    @(negedge clk);
    check("fuse_forces", osc_enable, 32'h1);
    $display("test soft done");
  endtask

  // Clear and clock switch both restart the count
  task automatic t_restart(input bit sw);
    int n;
    window_disable = 1'b1;
    do_reset();
    repeat (100) @(negedge clk);
    if (sw) pulse(clock_switch_done);
    else pulse(clear_watchdog_instr);
    check("no_early_req", wdt_reset_req, 32'h0);
    wait_for(400, 1'b0, n);
    in_range(sw ? "switch_restart" : "clear_restart", n, 32 * DIV);
    $display("test restart done");
  endtask

  // Window mode: early clear resets, late clear restarts
  task automatic t_window();
    int n;
    window_disable = 1'b0;
    do_reset();
    repeat (20) @(negedge clk);
    pulse(clear_watchdog_instr);
    check("early_req", wdt_reset_req, 32'h1);
    check("early_flag", timeout_flag, 32'h1);
    do_reset();
    repeat (110) @(negedge clk);
    pulse(clear_watchdog_instr);
    check("late_no_req", wdt_reset_req, 32'h0);
    wait_for(400, 1'b0, n);
    in_range("late_restart", n, 32 * DIV);
    window_disable = 1'b1;
    $display("test window done");
  endtask

  // Sleep or idle entry, watchdog wake, restart on exit
  task automatic t_power(input bit idle);
    int n;
    do_reset();
    repeat (50) @(negedge clk);
    power_save_idle = idle;
    pulse(power_save_instr);
    check("in_state", idle ? in_idle : in_sleep, 32'h1);
    check("state_flag", idle ? idle_flag : sleep_flag, 32'h1);
    repeat (60) @(negedge clk);
    pulse(clear_watchdog_instr);
    wait_for(400, 1'b1, n);
    in_range("wake_time", n + 62, 32 * DIV);
    check("no_reset_in_save", wdt_reset_req, 32'h0);
    @(negedge clk);
    check("left_state", idle ? in_idle : in_sleep, 32'h0);
    check("flag_kept", idle ? idle_flag : sleep_flag, 32'h1);
    wait_for(400, 1'b0, n);
    in_range("exit_restart", n + 1, 32 * DIV);
    if (idle) pulse(idle_flag_clr);
    else pulse(sleep_flag_clr);
    check("flag_clr", idle ? idle_flag : sleep_flag, 32'h0);
    pulse(power_save_instr);
    repeat (20) @(negedge clk);
    pulse(wake_event);
    check("wake_left", idle ? in_idle : in_sleep, 32'h0);
    check("wake_no_req", wake_req, 32'h0);
    wait_for(400, 1'b0, n);
    in_range("wake_restart", n, 32 * DIV);
    $display("test power done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_period();
    t_soft();
    t_restart(1'b0);
    t_restart(1'b1);
    t_window();
    t_power(1'b0);
    t_power(1'b1);
    close_out();
  end

  // Hang guard well beyond the expected run
  initial begin
    #(100000 * 4);
    errors++;
    close_out();
  end

endmodule // test_windowed_watchdog_timer

`default_nettype wire
